// ==== rtl/ttcu_consts.vh ====
`ifndef TTCU_CONSTS_VH
`define TTCU_CONSTS_VH

// Counter width
`define TTCU_CNT_W        16
// Service slot period in clock cycles
`define TTCU_SLOT_PERIOD  4
`define TTCU_SLOT_W       2
// Unit slot positions within the four-cycle round
`define TTCU_SLOT_A       2'h0
`define TTCU_SLOT_B       2'h1
`define TTCU_SLOT_I       2'h2
// Control word field positions (per external unit)
`define TTCU_CTL_EN       0
`define TTCU_CTL_EXTCLK   1
`define TTCU_CTL_PRESCL   2
`define TTCU_CTL_ALT      3
`define TTCU_CTL_CONT     4
`define TTCU_CTL_GATE     5
`define TTCU_CTL_W        6
// Internal unit control fields
`define TTCU_ICTL_EN      0
`define TTCU_ICTL_CONT    1
`define TTCU_ICTL_DMA     2
`define TTCU_ICTL_W       3
// Reset values
`define TTCU_CNT_RST      16'h0000
`define TTCU_MAX_RST      16'hFFFF

`endif

// ==== rtl/ttcu_ext_unit.v ====
`timescale 1ns/1ps
`include "ttcu_consts.vh"

// One pin-connected counter unit, serviced on its slot
module ttcu_ext_unit (
	input  wire                     ref_clk,
	input  wire                     rst,
	input  wire                     ce,
	input  wire                     slot_hit,
	input  wire [`TTCU_CTL_W-1:0]   ctl,
	input  wire [`TTCU_CNT_W-1:0]   max_a,
	input  wire [`TTCU_CNT_W-1:0]   max_b,
	input  wire                     pin_sync,
	input  wire                     prescale_tick,
	output reg  [`TTCU_CNT_W-1:0]   count_r,
	output reg                      out_r,
	output reg                      use_b_r,
	output reg                      done_r
);

	reg                   pin_prev_r;
	reg                   edge_pend_r;
	reg                   pre_pend_r;
	wire                  rise;
	wire                  adv;
	wire [`TTCU_CNT_W-1:0] lim;

	assign rise = pin_sync & ~pin_prev_r;
	// Alternate limit only in dual mode
	assign lim  = (ctl[`TTCU_CTL_ALT] && use_b_r) ? max_b : max_a;
	// Counting source: pin edge, prescaler, or every slot, gated by the pin level when GATE is set
	assign adv  = ctl[`TTCU_CTL_EXTCLK] ? (edge_pend_r | rise) :
		ctl[`TTCU_CTL_PRESCL] ? (pre_pend_r | prescale_tick) :
		(~ctl[`TTCU_CTL_GATE] | pin_sync);

	// Events are latched so none is lost between slots
	always @(posedge ref_clk) begin
		if (rst) begin
			pin_prev_r  <= 1'b1;
			edge_pend_r <= 1'b0;
			pre_pend_r  <= 1'b0;
			count_r     <= `TTCU_CNT_RST;
			out_r       <= 1'b1;
			use_b_r     <= 1'b0;
			done_r      <= 1'b0;
		end else if (ce) begin
			pin_prev_r <= pin_sync;
			if (slot_hit) begin
				edge_pend_r <= 1'b0;
				pre_pend_r  <= 1'b0;
			end else begin
				edge_pend_r <= edge_pend_r | rise;
				pre_pend_r  <= pre_pend_r | prescale_tick;
			end
			// Slot at most 4 cycles away, output within six of event
			if (slot_hit && ctl[`TTCU_CTL_EN] && !done_r && adv) begin
				if (count_r >= lim) begin
					count_r <= `TTCU_CNT_RST;
					if (ctl[`TTCU_CTL_ALT]) begin
						use_b_r <= ~use_b_r;
						out_r   <= use_b_r;
					end else begin
						out_r <= 1'b0;
					end
					if (!ctl[`TTCU_CTL_CONT])
						done_r <= 1'b1;
				end else begin
					count_r <= count_r + 16'h0001;
					if (!ctl[`TTCU_CTL_ALT])
						out_r <= 1'b1;
				end
			end
			// Disabling rearms a single-shot
			if (!ctl[`TTCU_CTL_EN])
				done_r <= 1'b0;
		end
	end

endmodule

// ==== rtl/ttcu_top.v ====
`timescale 1ns/1ps
`include "ttcu_consts.vh"

// Summary of operation
// - Three independent counters each hold a 16-bit count.
// - Units a and b each own an input and an output pin, the internal unit has no pins.
// - The internal unit can replace the count clock of units a and b as a prescaler.
// - The internal unit can issue a DMA request at each terminal count.
// - Units a and b count or time pin events and make single-shot or variable-duty waveforms.
// - Each unit is serviced once every fourth clock, so it counts at most at a quarter rate.
// - An output follows a clock or gate event on its input within six clocks.
// - No unit counts beyond its maximum count.
// - Units a and b alternate between primary and secondary maximum counts when enabled.
module ttcu_top (
	input  wire                     ref_clk,
	input  wire                     rst,
	input  wire                     ce,
	input  wire [`TTCU_CTL_W-1:0]   unit_a_ctl,
	input  wire [`TTCU_CNT_W-1:0]   unit_a_max_a,
	input  wire [`TTCU_CNT_W-1:0]   unit_a_max_b,
	input  wire [`TTCU_CTL_W-1:0]   unit_b_ctl,
	input  wire [`TTCU_CNT_W-1:0]   unit_b_max_a,
	input  wire [`TTCU_CNT_W-1:0]   unit_b_max_b,
	input  wire [`TTCU_ICTL_W-1:0]  unit_i_ctl,
	input  wire [`TTCU_CNT_W-1:0]   unit_i_max,
	input  wire                     unit_a_input_pin,
	input  wire                     unit_b_input_pin,
	output wire                     unit_a_output_pin,
	output wire                     unit_b_output_pin,
	output wire [`TTCU_CNT_W-1:0]   unit_a_count,
	output wire [`TTCU_CNT_W-1:0]   unit_b_count,
	output reg  [`TTCU_CNT_W-1:0]   unit_i_count_r,
	output reg                      dma_req_r
);

	reg  [`TTCU_SLOT_W-1:0] slot_r;
	reg  [1:0]              a_sync_r;
	reg  [1:0]              b_sync_r;
	reg                     pre_tick_r;
	reg                     i_done_r;
	wire                    a_out;
	wire                    b_out;

	// Slot decode, shared by all three units
	function slot_is;
		input [`TTCU_SLOT_W-1:0] cur;
		input [`TTCU_SLOT_W-1:0] own;
		begin
			slot_is = (cur == own);
		end
	endfunction

	// Round-robin service slot
	always @(posedge ref_clk) begin
		if (rst)
			slot_r <= `TTCU_SLOT_A;
		else if (ce)
			slot_r <= slot_r + 2'h1;
	end

	// Pins are asynchronous, two flops first
	// Reset to the pulled-up idle level, so release gives no false edge
	always @(posedge ref_clk) begin
		if (rst) begin
			a_sync_r <= 2'h3;
			b_sync_r <= 2'h3;
		end else if (ce) begin
			a_sync_r <= {a_sync_r[0], unit_a_input_pin};
			b_sync_r <= {b_sync_r[0], unit_b_input_pin};
		end
	end

	// Internal unit: no pins, feeds prescale and DMA
	always @(posedge ref_clk) begin
		if (rst) begin
			unit_i_count_r <= `TTCU_CNT_RST;
			pre_tick_r     <= 1'b0;
			dma_req_r      <= 1'b0;
			i_done_r       <= 1'b0;
		end else if (ce) begin
			pre_tick_r <= 1'b0;
			dma_req_r  <= 1'b0;
			if (!unit_i_ctl[`TTCU_ICTL_EN])
				i_done_r <= 1'b0;
			else if (slot_is(slot_r, `TTCU_SLOT_I) && !i_done_r) begin
				if (unit_i_count_r >= unit_i_max) begin
					unit_i_count_r <= `TTCU_CNT_RST;
					pre_tick_r     <= 1'b1;
					dma_req_r      <= unit_i_ctl[`TTCU_ICTL_DMA];
					if (!unit_i_ctl[`TTCU_ICTL_CONT])
						i_done_r <= 1'b1;
				end else begin
					unit_i_count_r <= unit_i_count_r + 16'h0001;
				end
			end
		end
	end

	// Two pin-connected units
	ttcu_ext_unit u_a (
		.ref_clk       (ref_clk),
		.rst           (rst),
		.ce            (ce),
		.slot_hit      (slot_is(slot_r, `TTCU_SLOT_A)),
		.ctl           (unit_a_ctl),
		.max_a         (unit_a_max_a),
		.max_b         (unit_a_max_b),
		.pin_sync      (a_sync_r[1]),
		.prescale_tick (pre_tick_r),
		.count_r       (unit_a_count),
		.out_r         (a_out),
		.use_b_r       (),
		.done_r        ()
	);

	ttcu_ext_unit u_b (
		.ref_clk       (ref_clk),
		.rst           (rst),
		.ce            (ce),
		.slot_hit      (slot_is(slot_r, `TTCU_SLOT_B)),
		.ctl           (unit_b_ctl),
		.max_a         (unit_b_max_a),
		.max_b         (unit_b_max_b),
		.pin_sync      (b_sync_r[1]),
		.prescale_tick (pre_tick_r),
		.count_r       (unit_b_count),
		.out_r         (b_out),
		.use_b_r       (),
		.done_r        ()
	);

	// Outputs are flop outputs of the units
	assign unit_a_output_pin = a_out;
	assign unit_b_output_pin = b_out;

endmodule

// ==== bench/ttcu_chk_assertions.sv ====
`timescale 1ns/1ps
`include "ttcu_consts.vh"
// Port-level watch on the counter unit
module ttcu_chk (
	input wire                    ref_clk,
	input wire                    rst,
	input wire                    ce,
	input wire [`TTCU_ICTL_W-1:0] unit_i_ctl,
	input wire [`TTCU_CNT_W-1:0]  unit_i_max,
	input wire [`TTCU_CNT_W-1:0]  unit_a_count,
	input wire [`TTCU_CNT_W-1:0]  unit_b_count,
	input wire [`TTCU_CNT_W-1:0]  unit_i_count_r,
	input wire                    dma_req_r
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// One service a round, so a change is followed by three quiet cycles
	sequence s_quiet(c);
		$stable(c)[*3];
	endsequence
	a_a_rate: assert property ($changed(unit_a_count) |=> s_quiet(unit_a_count)) else $error("a rate");
	a_b_rate: assert property ($changed(unit_b_count) |=> s_quiet(unit_b_count)) else $error("b rate");
	a_i_rate: assert property ($changed(unit_i_count_r) |=> s_quiet(unit_i_count_r)) else $error("i rate");
	a_i_bound: assert property (unit_i_count_r <= unit_i_max) else $error("i bound");
	a_i_step: assert property ($changed(unit_i_count_r) |->
		unit_i_count_r == $past(unit_i_count_r) + 1'b1 || unit_i_count_r == 0) else $error("i step");
	a_i_wrap: assert property ($changed(unit_i_count_r) && $past(unit_i_count_r) == unit_i_max |->
		unit_i_count_r == 0) else $error("i wrap");
	a_dma_pulse: assert property (dma_req_r |=> !dma_req_r) else $error("dma width");
	a_dma_tc: assert property (dma_req_r |-> unit_i_count_r == 0 && unit_i_ctl[`TTCU_ICTL_DMA])
		else $error("dma cause");
	a_ce_hold: assert property (!ce |=> $stable(unit_i_count_r) && $stable(unit_a_count))
		else $error("ce freeze");
endmodule
bind ttcu_top ttcu_chk i_ttcu_chk (.*);

// ==== bench/ttcu_pin_src.sv ====
`timescale 1ns/1ps
// Event source on the input pins; idles high as a pulled-up pin would
module ttcu_pin_src (
	input  wire ref_clk,
	input  wire go,
	output wire pin
);
	reg [2:0] ph_r;
	// Period of eight keeps edges two rounds apart, so none merge
	always @(posedge ref_clk) begin
		ph_r <= go ? ph_r + 3'h1 : 3'h0;
	end
	assign pin = !(go && ph_r < 3'h4);
endmodule

// ==== bench/test_triple_timer_counter_unit.sv ====
`timescale 1ns/1ps
`include "ttcu_consts.vh"
module test_triple_timer_counter_unit;
	reg                     ref_clk = 0, rst = 1, ce = 1, go = 0;
	reg  [`TTCU_CTL_W-1:0]  a_ctl = 0, b_ctl = 0;
	reg  [`TTCU_ICTL_W-1:0] i_ctl = 0;
	reg  [`TTCU_CNT_W-1:0]  a_mx = 0, a_my = 0, b_mx = 0, i_mx = 16'h0003;
	wire                    pin, a_out, b_out, dma;
	wire [`TTCU_CNT_W-1:0]  a_cnt, b_cnt, i_cnt;
	integer                 num_errors = 0, checks_done = 0, n, m;
	ttcu_top i_ttcu_top (.ref_clk(ref_clk), .rst(rst), .ce(ce), .unit_a_ctl(a_ctl), .unit_a_max_a(a_mx),
		.unit_a_max_b(a_my), .unit_b_ctl(b_ctl), .unit_b_max_a(b_mx), .unit_b_max_b(b_mx), .unit_i_ctl(i_ctl),
		.unit_i_max(i_mx), .unit_a_input_pin(pin), .unit_b_input_pin(pin), .unit_a_output_pin(a_out),
		.unit_b_output_pin(b_out), .unit_a_count(a_cnt), .unit_b_count(b_cnt), .unit_i_count_r(i_cnt),
		.dma_req_r(dma));
	ttcu_pin_src i_ttcu_pin_src (.ref_clk(ref_clk), .go(go), .pin(pin));
	// 100 MHz clock
	always #5 ref_clk = ~ref_clk;
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done = checks_done + 1;
		if (s !== e) begin
			num_errors = num_errors + 1;
			$display("ERROR %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task final_report;
		if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Inputs move 1 ns after the edge, clear of sampling
	task tk(input integer k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	function logic sel(input integer w);
		sel = w == 0 ? dma : w == 1 ? a_out : b_out;
	endfunction
	// Bounded wait for a level; a hang ends the run as a failure
	task wt(input integer w, input logic v, output integer c);
		c = 0;
		while (sel(w) !== v && c < 300) begin
			tk(1);
			c = c + 1;
		end
		if (c == 300) begin
			chk("wait", 0, 1);
			final_report;
		end
	endtask
	// Config only under reset, so a lowered limit never meets a high count
	task cfg(input [5:0] ac, input [5:0] bc, input [2:0] ic, input [15:0] am, input [15:0] ay, input [15:0] bm);
		rst = 1;
		{a_ctl, b_ctl, i_ctl, a_mx, a_my, b_mx} = {ac, bc, ic, am, ay, bm};
		tk(10);
		chk("rst_out", {a_out, b_out, dma}, 3'h6);
		chk("rst_cnt", a_cnt | b_cnt | i_cnt, 0);
		rst = 0;
	endtask
	// Internal unit: request period, and as prescaler of unit b
	task t_int;
		cfg(6'h00, 6'h15, 3'h7, 16'h0000, 16'h0000, 16'h0001);
		wt(0, 1, n);
		wt(0, 0, n);
		wt(0, 1, m);
		chk("dma_period", n + m, 16);
		wt(2, 0, n);
		wt(2, 1, n);
		wt(2, 0, m);
		chk("b_prescaled", n + m, 32);
	endtask
	// Pin edges counted on a and answered promptly on b
	task t_pin;
		cfg(6'h13, 6'h13, 3'h0, 16'h00ff, 16'h0000, 16'h0000);
		go = 1;
		wt(2, 0, n);
		chk("b_latency", n <= 10, 1);
		tk(36 - n);
		go = 0;
		tk(12);
		chk("a_events", a_cnt, 5);
		chk("b_count", b_cnt, 0);
	endtask
	// Alternating limits on a, single-shot on b, clock enable freeze
	task t_alt;
		cfg(6'h19, 6'h01, 3'h0, 16'h0002, 16'h0005, 16'h0004);
		wt(1, 0, n);
		wt(1, 1, n);
		wt(1, 0, m);
		chk("alt_low", n, 24);
		chk("alt_high", m, 12);
		ce = 0;
		m = a_cnt;
		tk(8);
		chk("ce_hold", a_cnt, m);
		ce = 1;
		chk("single_a", b_cnt, 0);
		tk(4);
		chk("single_b", b_cnt, 0);
	endtask
	initial begin
		t_int;
		t_pin;
		t_alt;
		final_report;
	end
endmodule
